// ---- rnf_filter.sv ----
`timescale 1ns/1ps
`default_nettype none
module rnf_filter #(
    parameter int unsigned CNT_W = rnf_pkg::RNF_CNT_W
) (
    input  wire logic         MCLK,
    input  wire logic         RESETN,
    input  wire logic         CE,
    input  wire logic         TIMER_INPUT_PIN,
    input  wire logic         BIT_MID,
    output var  logic         FILT_OUT,
    output var  logic         NOISE_EVENT_FLAG,
    output var  rnf_pkg::rnf_sample_s SMP_OUT,
    output var  logic         SMP_VALID
);
    import rnf_pkg::*;

    localparam logic [CNT_W-1:0] CNT_MAX  = {CNT_W{1'b1}};
    localparam logic [CNT_W-1:0] CNT_MIN  = {CNT_W{1'b0}};
    localparam logic [CNT_W-1:0] CNT_ONE  = {{(CNT_W-1){1'b0}}, 1'b1};
    localparam logic [CNT_W-1:0] CNT_HIGH = CNT_MAX - CNT_ONE;
    // idle line is high, so start saturated at the top
    localparam logic [CNT_W-1:0] CNT_RST  = {CNT_W{RNF_IDLE_LEVEL}};

    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic             filt_ff;
    logic             nxt_filt;
    logic             noise_ff;
    logic             nxt_noise;
    rnf_sample_s      smp_ff;
    rnf_sample_s      nxt_smp;
    logic             smp_vld_ff;

    wire at_max  = (cnt_ff == CNT_MAX);
    wire at_min  = (cnt_ff == CNT_MIN);
    wire step_up = TIMER_INPUT_PIN && !at_max;
    wire step_dn = !TIMER_INPUT_PIN && !at_min;

    // saturating step, never wraps past either end
    assign nxt_cnt = step_up ? cnt_ff + CNT_ONE :
                     step_dn ? cnt_ff - CNT_ONE : cnt_ff;

    // output moves only when the count lands on an extreme
    wire fall_now = step_dn && (cnt_ff == CNT_ONE);
    wire rise_now = step_up && (cnt_ff == CNT_HIGH);
    assign nxt_filt = rise_now ? 1'b1 :
                      fall_now ? 1'b0 : filt_ff;

    // any count short of an extreme means the line disagreed recently
    assign nxt_noise = (nxt_cnt != CNT_MAX) && (nxt_cnt != CNT_MIN);

    // data and flag taken from the same registered instant
    assign nxt_smp.data  = filt_ff;
    assign nxt_smp.noise = noise_ff;

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            cnt_ff   <= CNT_RST;
            filt_ff  <= RNF_IDLE_LEVEL;
            noise_ff <= 1'b0;
        end else if (CE) begin
            cnt_ff   <= nxt_cnt;
            filt_ff  <= nxt_filt;
            noise_ff <= nxt_noise;
        end
    end

    // the timer's bit timing places the strobe at the bit centre
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            smp_ff     <= '{data: RNF_IDLE_LEVEL, noise: RNF_SMP_IDLE};
            smp_vld_ff <= RNF_SMP_IDLE;
        end else if (CE) begin
            smp_vld_ff <= BIT_MID;
            if (BIT_MID) begin
                smp_ff <= nxt_smp;
            end
        end
    end

    assign FILT_OUT         = filt_ff;
    assign NOISE_EVENT_FLAG = noise_ff;
    assign SMP_OUT          = smp_ff;
    assign SMP_VALID        = smp_vld_ff;

    // assertions
    property p_no_wrap_up;
        @(posedge MCLK) disable iff (!RESETN)
        (CE && at_max && TIMER_INPUT_PIN) |=> (cnt_ff == CNT_MAX);
    endproperty
    a_no_wrap_up: assert property (p_no_wrap_up)
        else $error("counter wrapped above top");

    property p_no_wrap_dn;
        @(posedge MCLK) disable iff (!RESETN)
        (CE && at_min && !TIMER_INPUT_PIN) |=> (cnt_ff == CNT_MIN);
    endproperty
    a_no_wrap_dn: assert property (p_no_wrap_dn)
        else $error("counter wrapped below bottom");

    property p_step_dir;
        @(posedge MCLK) disable iff (!RESETN)
        (CE && !at_max && !at_min) |=>
            (cnt_ff == ($past(TIMER_INPUT_PIN) ? $past(cnt_ff) + CNT_ONE
                                               : $past(cnt_ff) - CNT_ONE));
    endproperty
    a_step_dir: assert property (p_step_dir)
        else $error("counter stepped the wrong way");

    property p_frozen;
        @(posedge MCLK) disable iff (!RESETN)
        !CE |=> ($stable(cnt_ff) && $stable(FILT_OUT) && $stable(SMP_OUT));
    endproperty
    a_frozen_state: assert property (p_frozen)
        else $error("state moved with enable low");

    property p_fall_cause;
        @(posedge MCLK) disable iff (!RESETN)
        $fell(FILT_OUT) |->
            ($past(cnt_ff) == CNT_ONE) && (cnt_ff == CNT_MIN);
    endproperty
    a_fall_cause: assert property (p_fall_cause)
        else $error("output fell away from bottom step");

    property p_rise_cause;
        @(posedge MCLK) disable iff (!RESETN)
        $rose(FILT_OUT) |->
            ($past(cnt_ff) == CNT_HIGH) && (cnt_ff == CNT_MAX);
    endproperty
    a_rise_cause: assert property (p_rise_cause)
        else $error("output rose away from top step");

    property p_fall_taken;
        @(posedge MCLK) disable iff (!RESETN)
        (CE && cnt_ff == CNT_ONE && !TIMER_INPUT_PIN) |=> !FILT_OUT;
    endproperty
    a_fall_taken: assert property (p_fall_taken)
        else $error("output missed its fall");

    property p_rise_taken;
        @(posedge MCLK) disable iff (!RESETN)
        (CE && cnt_ff == CNT_HIGH && TIMER_INPUT_PIN) |=> FILT_OUT;
    endproperty
    a_rise_taken: assert property (p_rise_taken)
        else $error("output missed its rise");

    property p_extreme_level;
        @(posedge MCLK) disable iff (!RESETN)
        (at_max |-> FILT_OUT) and (at_min |-> !FILT_OUT);
    endproperty
    a_extreme_level: assert property (p_extreme_level)
        else $error("output disagrees with saturated count");

    // lag figure holds for the two-bit counter only
    generate
        if (CNT_W == RNF_CNT_W) begin : g_lag
            sequence s_clean_low;
                (CE && !TIMER_INPUT_PIN && at_max && FILT_OUT)
                ##1 (CE && !TIMER_INPUT_PIN) [*2];
            endsequence
            sequence s_clean_high;
                (CE && TIMER_INPUT_PIN && at_min && !FILT_OUT)
                ##1 (CE && TIMER_INPUT_PIN) [*2];
            endsequence
            property p_lag_low;
                @(posedge MCLK) disable iff (!RESETN)
                s_clean_low |-> FILT_OUT ##1 !FILT_OUT;
            endproperty
            property p_lag_high;
                @(posedge MCLK) disable iff (!RESETN)
                s_clean_high |-> !FILT_OUT ##1 FILT_OUT;
            endproperty
            a_lag_low: assert property (p_lag_low)
                else $error("falling edge lag is not three clocks");
            a_lag_high: assert property (p_lag_high)
                else $error("rising edge lag is not three clocks");
        end
    endgenerate

    sequence s_strobe;
        CE && BIT_MID;
    endsequence
    property p_sample_pair;
        @(posedge MCLK) disable iff (!RESETN)
        s_strobe |=> SMP_VALID && (SMP_OUT.data == $past(FILT_OUT))
                     && (SMP_OUT.noise == $past(NOISE_EVENT_FLAG));
    endproperty
    a_sample_pair: assert property (p_sample_pair)
        else $error("sample pair not taken at the strobe");

    property p_data_clean;
        @(posedge MCLK) disable iff (!RESETN)
        (s_strobe ##0 NOISE_EVENT_FLAG) |=>
            (SMP_OUT.data == $past(FILT_OUT));
    endproperty
    a_data_clean: assert property (p_data_clean)
        else $error("noise altered the sampled bit");

    property p_sample_hold;
        @(posedge MCLK) disable iff (!RESETN)
        !(CE && BIT_MID) |=> $stable(SMP_OUT);
    endproperty
    a_sample_hold: assert property (p_sample_hold)
        else $error("sample changed without a strobe");

    // valid is as wide as the BIT_MID strobe, longer only while enable stays low
    property p_valid_drop;
        @(posedge MCLK) disable iff (!RESETN)
        (CE && !BIT_MID) |=> !SMP_VALID;
    endproperty
    a_valid_drop: assert property (p_valid_drop)
        else $error("valid stood without a strobe");

    property p_valid_frozen;
        @(posedge MCLK) disable iff (!RESETN)
        !CE |=> $stable(SMP_VALID);
    endproperty
    a_valid_frozen: assert property (p_valid_frozen)
        else $error("valid moved with enable low");

    // flag and count share one register edge, so they never disagree
    property p_noise_mid;
        @(posedge MCLK) disable iff (!RESETN)
        NOISE_EVENT_FLAG == (!at_max && !at_min);
    endproperty
    a_noise_mid: assert property (p_noise_mid)
        else $error("noise flag disagrees with count");
endmodule
`default_nettype wire

// ---- rnf_pkg.sv ----
// Behaviour
// - two-bit saturating up/down counter, no wrap
// - output falls only on step 01 to 00
// - output rises only on step 10 to 11
// - clean input reaches output three clocks later
// - counter width is a parameter; the three-clock lag holds for two bits only
// - data sampled near bit centre strobe
// - noise flag captured with the data bit
// - noise flag never alters sampled data
`default_nettype none
package rnf_pkg;
    localparam int unsigned RNF_CNT_W      = 2;
    localparam logic        RNF_IDLE_LEVEL = 1'b1;
    localparam logic        RNF_SMP_IDLE   = 1'b0;
    localparam int unsigned RNF_LAG_CLEAN  = 3;

    typedef struct packed {
        logic data;
        logic noise;
    } rnf_sample_s;
endpackage
`default_nettype wire

// ---- rnf_line_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// idle-high serial line; follows the bench's level one edge later,
// so every line change is launched just after a clock edge
module rnf_line_model (
    input  wire logic mclk,
    input  wire logic level,
    output var  logic pin
);
    always_ff @(posedge mclk) begin
        pin <= level;
    end
endmodule
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import rnf_pkg::*;
    logic        mclk, resetn, ce, bit_mid, lvl;
    logic        pin, filt, noise, valid;
    rnf_sample_s smp;
    int          errors = 0;
    int          n_compared = 0;

    rnf_line_model line_u (.mclk(mclk), .level(lvl), .pin(pin));
    rnf_filter dut_u (
        .MCLK(mclk), .RESETN(resetn), .CE(ce),
        .TIMER_INPUT_PIN(pin), .BIT_MID(bit_mid), .FILT_OUT(filt),
        .NOISE_EVENT_FLAG(noise), .SMP_OUT(smp), .SMP_VALID(valid));

    task automatic end_sim;
        if (errors == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [1:0] seen, input logic [1:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: saw %b, want %b", $time, seen, exp);
        end
    endtask

    // sample 1 ns after the edge so its updates have landed
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic drive(input logic v);
        @(posedge mclk);
        lvl <= v;
        #1;
    endtask

    // full fall then full rise; long low hold proves no wrap at 00
    task automatic clean_scn;
        drive(1'b0);
        step(3); chk({filt, noise}, 2'b11);
        step(1); chk({filt, noise}, 2'b00);
        step(6); chk({filt, noise}, 2'b00);
        drive(1'b1);
        step(3); chk({filt, noise}, 2'b01);
        step(1); chk({filt, noise}, 2'b10);
    endtask

    // two-sample low pulse, strobed while the counter sits at 01
    task automatic glitch_scn;
        drive(1'b0);
        drive(1'b0);
        drive(1'b1);
        @(posedge mclk);
        bit_mid <= 1'b1;
        #1;
        chk({filt, noise}, 2'b11);
        @(posedge mclk);
        bit_mid <= 1'b0;
        #1;
        chk({valid, filt}, 2'b11);
        chk(smp, 2'b11);
        step(1); chk({valid, filt}, 2'b01);
        step(2); chk({filt, noise}, 2'b10);
    endtask

    // enable low freezes counter and ignores strobes
    task automatic hold_scn;
        @(posedge mclk);
        ce <= 1'b0;
        bit_mid <= 1'b1;
        lvl <= 1'b0;
        step(6); chk({filt, noise}, 2'b10);
        chk({valid, 1'b0}, 2'b00);
        @(posedge mclk);
        ce <= 1'b1;
        bit_mid <= 1'b0;
        #1;
        step(2); chk({filt, noise}, 2'b11);
        step(1); chk({filt, noise}, 2'b00);
        // strobes under enable low were refused, glitch sample stays
        step(1); chk(smp, 2'b11);
        drive(1'b1);
        step(5); chk({filt, noise}, 2'b10);
    endtask

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    initial begin
        #200us;
        errors++;
        end_sim();
    end

    initial begin
        resetn = 1'b0;
        ce = 1'b1;
        bit_mid = 1'b0;
        lvl = 1'b1;
        step(4);
        chk({filt, noise}, 2'b10);
        chk({valid, 1'b0}, 2'b00);
        chk(smp, 2'b10);
        resetn <= 1'b0;
        @(posedge mclk);
        resetn <= 1'b1;
        step(2);
        clean_scn();
        glitch_scn();
        hold_scn();
        end_sim();
    end
endmodule
`default_nettype wire
